// ### common/ltt_map.svh
// register offsets, field positions, reset values and byte thresholds of the tuning block
`ifndef LTT_MAP_SVH
`define LTT_MAP_SVH

`define LTT_OFF_TUNING   8'hF4
`define LTT_OFF_HOSTCTL  8'h50
`define LTT_OFF_RETRIES  8'h08
`define LTT_OFF_STATUS   8'h0C

`define LTT_TUNING_RESET 32'h0000_1000
`define LTT_TUNING_WMASK 32'h0000_B580
`define LTT_HOSTCTL_RESET 32'h0000_0000
`define LTT_RETRIES_RESET 32'h0000_0000

`define LTT_BIT_REORDER  15
`define LTT_THR_HI       13
`define LTT_THR_LO       12
`define LTT_BIT_MPEG     10
`define LTT_BIT_DV       8
`define LTT_BIT_PRIO     7
`define LTT_BIT_GATE     22

`define LTT_THR_2K       2'h0
`define LTT_THR_1K7      2'h1
`define LTT_THR_1K       2'h2
`define LTT_THR_512      2'h3

`define LTT_BYTES_2K     12'h800
`define LTT_BYTES_1K7    12'h6CC
`define LTT_BYTES_1K     12'h400
`define LTT_BYTES_512    12'h200
`define LTT_WORD_BYTES   12'h004

`define LTT_FMT_MPEG     6'h20
`define LTT_FMT_DV       6'h00

`endif

// ### common/ltt_pkg.sv
// types shared by the transmit tuning block
package ltt_pkg;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_fill = 2'b01,
    st_send = 2'b10
  } ltt_state_type;

endpackage : ltt_pkg

// ### logic/ltt_fifo.sv
// small staging fifo with valid and ready on both sides
`timescale 1ns/10ps
module ltt_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  wire              push;
  wire              pop;

  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // depth must be a power of two so the pointers wrap by themselves
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else if (ce)
    begin
      if (push)
        mem_q[wr_ptr_q] <= in_data;
      if (push)
        wr_ptr_q <= wr_ptr_q + AW'(1);
      if (pop)
        rd_ptr_q <= rd_ptr_q + AW'(1);
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : ltt_fifo

// ### logic/ltt_thresh.sv
// start-level decode and the decision to begin sending
`timescale 1ns/10ps
`include "ltt_map.svh"
module ltt_thresh (
  // programmed level and forcing
  input  wire logic [1:0]  code,
  input  wire logic        force_sf,
  // packet progress
  input  wire logic [11:0] bytes_loaded,
  input  wire logic        eop_loaded,
  // decision
  output logic [11:0]      thresh_bytes,
  output logic             go
);

  wire store_fwd;

  assign thresh_bytes = (code == `LTT_THR_512) ? `LTT_BYTES_512 :
                        (code == `LTT_THR_1K)  ? `LTT_BYTES_1K  :
                        (code == `LTT_THR_1K7) ? `LTT_BYTES_1K7 : `LTT_BYTES_2K;
  assign store_fwd    = force_sf | (code == `LTT_THR_2K);
  // a whole packet may always leave, even below the level
  assign go = eop_loaded | (~store_fwd & (bytes_loaded >= thresh_bytes));

endmodule : ltt_thresh

// ### logic/ltt_top.sv
// transmit tuning register, wishbone slave and asynchronous transmit start control
`timescale 1ns/10ps
`include "ltt_map.svh"
module ltt_top (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // serial eeprom load
  input  wire logic        eeprom_present,
  input  wire logic        eeprom_load,
  input  wire logic [15:0] eeprom_data,
  // host transmit data
  input  wire logic [31:0] tx_in_data,
  input  wire logic        tx_in_last,
  input  wire logic        tx_in_valid,
  output logic             tx_in_ready,
  // into the asynchronous transmit fifo
  output logic      [31:0] at_out_data,
  output logic             at_out_last,
  output logic             at_out_valid,
  input  wire logic        at_out_ready,
  // link side
  input  wire logic        at_fifo_empty,
  input  wire logic        link_tx_done,
  output logic             tx_go,
  output logic             tx_underrun,
  // stream and arbitration controls
  input  wire logic [5:0]  cip_fmt,
  output logic             stamp_boost,
  output logic             async_tx_reorder_disable,
  output logic             priority_arb_en
);

  logic [31:0]              tun_q;
  logic [31:0]              tun_d;
  logic [31:0]              hostctl_q;
  logic [31:0]              retries_q;
  logic [31:0]              rdata_q;
  logic                     ack_q;
  logic [11:0]              bytes_q;
  logic                     eop_q;
  logic                     retry_q;
  logic                     underrun_q;
  logic                     reorder_q;
  logic                     prio_q;
  ltt_pkg::ltt_state_type   state_q;
  ltt_pkg::ltt_state_type   state_d;

  wire [31:0] lane_mask;
  wire [31:0] wmask;
  wire [31:0] ee_word;
  wire        access;
  wire        wr_en;
  wire        sel_tun;
  wire        sel_hostctl;
  wire        sel_retries;
  wire        sel_status;
  wire [31:0] status_w;
  wire [31:0] rd_mux;
  wire        gate;
  wire        force_sf;
  wire        go;
  wire [11:0] thresh_bytes;
  wire [32:0] fifo_out;
  wire        fifo_valid;
  wire        out_fire;
  wire        underrun_now;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++)
    begin : g_lane
      assign lane_mask[lane*8 +: 8] = {8{wb_sel_i[lane]}};
    end
  endgenerate

  // register bus decode
  assign access      = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_en       = access & wb_we_i & ce;
  assign sel_tun     = (wb_adr_i == `LTT_OFF_TUNING);
  assign sel_hostctl = (wb_adr_i == `LTT_OFF_HOSTCTL);
  assign sel_retries = (wb_adr_i == `LTT_OFF_RETRIES);
  assign sel_status  = (wb_adr_i == `LTT_OFF_STATUS);
  assign wmask       = `LTT_TUNING_WMASK & lane_mask;
  assign ee_word     = {16'h0000, eeprom_data};

  // only the writable fields ever change, so reserved bits stay zero
  always_comb
  begin
    tun_d = tun_q;
    if (wr_en & sel_tun)
      tun_d = (tun_q & ~wmask) | (wb_dat_i & wmask);
    if (eeprom_present & eeprom_load)
      tun_d = (tun_d & ~`LTT_TUNING_WMASK) | (ee_word & `LTT_TUNING_WMASK);
  end

  assign status_w = {4'h0, bytes_q, 8'h00, underrun_q, retry_q, eop_q, gate,
                     2'b00, state_q};
  assign rd_mux   = sel_tun     ? tun_q :
                    sel_hostctl ? hostctl_q :
                    sel_retries ? retries_q :
                    sel_status  ? status_w : 32'h0000_0000;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tun_q     <= `LTT_TUNING_RESET;
      hostctl_q <= `LTT_HOSTCTL_RESET;
      retries_q <= `LTT_RETRIES_RESET;
      rdata_q   <= 32'h0000_0000;
      ack_q     <= 1'b0;
    end
    else if (ce)
    begin
      tun_q <= tun_d;
      if (wr_en & sel_hostctl)
        hostctl_q[`LTT_BIT_GATE] <= wb_dat_i[`LTT_BIT_GATE] & wb_sel_i[2];
      if (wr_en & sel_retries)
        retries_q <= (retries_q & ~lane_mask) | (wb_dat_i & lane_mask);
      ack_q   <= access;
      rdata_q <= rd_mux;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // enhancement controls
  assign gate     = hostctl_q[`LTT_BIT_GATE];
  assign force_sf = retry_q | (retries_q == 32'h0000_0000) | ~gate;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      reorder_q <= 1'b0;
      prio_q    <= 1'b0;
    end
    else if (ce)
    begin
      reorder_q <= gate & tun_q[`LTT_BIT_REORDER];
      prio_q    <= gate & tun_q[`LTT_BIT_PRIO];
    end
  end

  assign async_tx_reorder_disable = reorder_q;
  assign priority_arb_en          = prio_q;
  assign stamp_boost = gate & ((tun_q[`LTT_BIT_MPEG] & (cip_fmt == `LTT_FMT_MPEG)) |
                               (tun_q[`LTT_BIT_DV] & (cip_fmt == `LTT_FMT_DV)));

  // data path: the next packet is held back until the current one is sent
  ltt_fifo #(
    .WIDTH (33),
    .DEPTH (4)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .in_data   ({tx_in_last, tx_in_data}),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (at_out_ready & ~eop_q)
  );

  assign at_out_data  = fifo_out[31:0];
  assign at_out_last  = fifo_out[32];
  assign at_out_valid = fifo_valid & ~eop_q;
  assign out_fire     = at_out_valid & at_out_ready;

  ltt_thresh u_thresh (
    .code         (tun_q[`LTT_THR_HI:`LTT_THR_LO]),
    .force_sf     (force_sf),
    .bytes_loaded (bytes_q),
    .eop_loaded   (eop_q),
    .thresh_bytes (thresh_bytes),
    .go           (go)
  );

  // start sequencing
  assign underrun_now = (state_q == ltt_pkg::st_send) & at_fifo_empty & ~eop_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ltt_pkg::st_idle:
        if (out_fire)
          state_d = ltt_pkg::st_fill;
      ltt_pkg::st_fill:
        if (go)
          state_d = ltt_pkg::st_send;
      ltt_pkg::st_send:
        if (link_tx_done)
          state_d = ltt_pkg::st_idle;
        else if (underrun_now)
          state_d = ltt_pkg::st_fill;
      default:
        state_d = ltt_pkg::st_idle;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q    <= ltt_pkg::st_idle;
      bytes_q    <= 12'h000;
      eop_q      <= 1'b0;
      retry_q    <= 1'b0;
      underrun_q <= 1'b0;
    end
    else if (ce)
    begin
      state_q    <= state_d;
      underrun_q <= underrun_now & ~link_tx_done;
      if ((state_q == ltt_pkg::st_send) & link_tx_done)
      begin
        bytes_q <= 12'h000;
        eop_q   <= 1'b0;
        retry_q <= 1'b0;
      end
      else
      begin
        // count saturates at the largest level to stay within 12 bits
        if (out_fire & (bytes_q < `LTT_BYTES_2K))
          bytes_q <= bytes_q + `LTT_WORD_BYTES;
        if (out_fire & at_out_last)
          eop_q <= 1'b1;
        if (underrun_now)
          retry_q <= 1'b1;
      end
    end
  end

  assign tx_go       = (state_q == ltt_pkg::st_send);
  assign tx_underrun = underrun_q;

  a_reset_value: assert property (@(posedge sys_clk)
    $past(rst) && !rst |-> tun_q == `LTT_TUNING_RESET)
    else $error("tuning register not at reset value");

  a_reserved_read: assert property (@(posedge sys_clk) disable iff (rst)
    wb_ack_o && $past(sel_tun) |-> (wb_dat_o & ~`LTT_TUNING_WMASK) == 32'h0000_0000)
    else $error("reserved tuning bits read nonzero");

  a_ro_write_kept: assert property (@(posedge sys_clk) disable iff (rst)
    ce && wr_en && sel_tun && !eeprom_load |=> (tun_q & ~`LTT_TUNING_WMASK) == 32'h0)
    else $error("write reached a read-only tuning bit");

  a_eeprom_load: assert property (@(posedge sys_clk) disable iff (rst)
    ce && eeprom_present && eeprom_load
    |=> (tun_q & `LTT_TUNING_WMASK) == ($past(ee_word) & `LTT_TUNING_WMASK))
    else $error("eeprom word not loaded");

  a_gate_off_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    !gate && !$past(gate) |-> !async_tx_reorder_disable && !priority_arb_en && !stamp_boost)
    else $error("enhancement active without gate");

  a_reorder_follow: assert property (@(posedge sys_clk) disable iff (rst)
    ce && gate && tun_q[`LTT_BIT_REORDER] |=> async_tx_reorder_disable)
    else $error("pipelining not disabled");

  a_prio_follow: assert property (@(posedge sys_clk) disable iff (rst)
    ce && gate && tun_q[`LTT_BIT_PRIO] |=> priority_arb_en)
    else $error("priority arbitration not enabled");

  a_mpeg_boost: assert property (@(posedge sys_clk) disable iff (rst)
    gate && tun_q[`LTT_BIT_MPEG] && cip_fmt == 6'h20 |-> stamp_boost)
    else $error("mpeg timestamp boost missing");

  a_dv_boost: assert property (@(posedge sys_clk) disable iff (rst)
    gate && tun_q[`LTT_BIT_DV] && cip_fmt == 6'h00 |-> stamp_boost)
    else $error("dv timestamp boost missing");

  a_level_start: assert property (@(posedge sys_clk) disable iff (rst)
    ce && state_q == ltt_pkg::st_fill && !force_sf && tun_q[13:12] == 2'h3
    && bytes_q >= 12'h200 |=> tx_go)
    else $error("no start at 512 byte level");

  a_sf_complete: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(tx_go) && (tun_q[13:12] == 2'h0 || retries_q == 32'h0) |-> eop_q)
    else $error("store-and-forward started before packet end");

  a_underrun_retry: assert property (@(posedge sys_clk) disable iff (rst)
    tx_underrun |-> retry_q && !tx_go ##1 (!tx_go || eop_q))
    else $error("underrun did not force whole-packet retry");

endmodule : ltt_top

// ### testbench/ltt_link_model.sv
// link-side model: takes fifo words and drains them while sending
`timescale 1ns/10ps
module ltt_link_model (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // stall from the bench
  input  wire logic hold,
  // transmit fifo side
  input  wire logic at_out_valid,
  input  wire logic at_out_last,
  output logic      at_out_ready,
  output logic      at_fifo_empty,
  // link side
  input  wire logic tx_go,
  output logic      link_tx_done
);
  logic [11:0] cnt_q;
  logic        last_q;
  logic        ph_q;
  wire         take = at_out_valid & at_out_ready;
  // half-rate drain so a steady host keeps ahead, an idle one underruns
  wire         drain = tx_go & ph_q & (cnt_q != 12'h000);
  assign at_out_ready  = ~hold;
  assign at_fifo_empty = (cnt_q == 12'h000);
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_q        <= 12'h000;
      last_q       <= 1'b0;
      ph_q         <= 1'b0;
      link_tx_done <= 1'b0;
    end
    else
    begin
      ph_q         <= ~ph_q;
      cnt_q        <= cnt_q + {11'h000, take} - {11'h000, drain};
      last_q       <= (last_q | (take & at_out_last)) & ~link_tx_done;
      link_tx_done <= tx_go & at_fifo_empty & last_q & ~link_tx_done;
    end
  end
endmodule : ltt_link_model

// ### testbench/tb_ltt_top.sv
// bench for the transmit tuning block: registers, gating and start control
`timescale 1ns/10ps
`include "ltt_map.svh"
module tb_ltt_top;
  logic        sys_clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, hold = 1'b0;
  logic        ep = 1'b0, el = 1'b0, tv = 1'b0, tl = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000, td = 32'h0000_0000, q;
  logic [15:0] ed = 16'h0000;
  logic [5:0]  fmt = 6'h20;
  logic [31:0] dato, aod;
  logic        ack, rdy, aol, aov, aor, afe, done, go, urun, boost, reo, prio;
  int          n_errors = 0, compares = 0, c, nw;
  always #25 sys_clk = ~sys_clk;
  ltt_top dut (.sys_clk(sys_clk), .rst(rst), .ce(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wd), .wb_dat_o(dato), .wb_ack_o(ack),
    .eeprom_present(ep), .eeprom_load(el), .eeprom_data(ed),
    .tx_in_data(td), .tx_in_last(tl), .tx_in_valid(tv), .tx_in_ready(rdy),
    .at_out_data(aod), .at_out_last(aol), .at_out_valid(aov), .at_out_ready(aor),
    .at_fifo_empty(afe), .link_tx_done(done), .tx_go(go), .tx_underrun(urun),
    .cip_fmt(fmt), .stamp_boost(boost), .async_tx_reorder_disable(reo),
    .priority_arb_en(prio));
  ltt_link_model link (.sys_clk(sys_clk), .rst(rst), .hold(hold), .at_out_valid(aov),
    .at_out_last(aol), .at_out_ready(aor), .at_fifo_empty(afe), .tx_go(go),
    .link_tx_done(done));
  task automatic final_report;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input int k);
    if (k >= 2000)
    begin
      n_errors++;
      final_report();
    end
  endtask : tmo
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    k = 0;
    // ack is read at the rising edge, before that edge updates it
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (ack !== 1'b1 && k < 2000);
    tmo(k);
    q = dato;
    cyc <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle
  task automatic eload(input logic p, input logic [15:0] d);
    @(posedge sys_clk);
    ep <= p;
    ed <= d;
    el <= 1'b1;
    @(posedge sys_clk);
    el <= 1'b0;
  endtask : eload
  // holds valid across words; it drops only after the final word is taken
  task automatic send(input int n, input logic lst);
    int i, k;
    @(posedge sys_clk);
    tv <= 1'b1;
    for (i = 0; i < n; i++)
    begin
      td <= td + 32'h1;
      tl <= lst && (i == n - 1);
      k = 0;
      do begin @(negedge sys_clk); k++; end while (rdy !== 1'b1 && k < 2000);
      tmo(k);
      @(posedge sys_clk);
    end
    tv <= 1'b0;
    tl <= 1'b0;
  endtask : send
  task automatic wait_hi(input logic u);
    int k;
    k = 0;
    do begin @(negedge sys_clk); k++; end while ((u ? urun : done) !== 1'b1 && k < 2000);
    tmo(k);
  endtask : wait_hi
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`LTT_OFF_TUNING, 32'h0000_1000);
    rd(`LTT_OFF_RETRIES, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    wr(`LTT_OFF_TUNING, 32'hFFFF_FFFF);
    rd(`LTT_OFF_TUNING, 32'h0000_B580);
    idle(3);
    chk(reo, 1'b0);
    chk(prio, 1'b0);
    chk(boost, 1'b0);
    wr(`LTT_OFF_HOSTCTL, 32'hFFFF_FFFF);
    rd(`LTT_OFF_HOSTCTL, 32'h0040_0000);
    idle(3);
    chk(reo, 1'b1);
    chk(prio, 1'b1);
    chk(boost, 1'b1);
    wr(`LTT_OFF_TUNING, 32'h0000_0400);
    fmt <= 6'h00;
    idle(3);
    chk(boost, 1'b0);
    wr(`LTT_OFF_TUNING, 32'h0000_0100);
    idle(3);
    chk(boost, 1'b1);
    fmt <= 6'h20;
    idle(2);
    chk(boost, 1'b0);
    eload(1'b0, 16'hFFFF);
    rd(`LTT_OFF_TUNING, 32'h0000_0100);
    eload(1'b1, 16'hFFFF);
    rd(`LTT_OFF_TUNING, 32'h0000_B580);
    $display("test registers and gating done");
    wr(`LTT_OFF_TUNING, 32'h0000_0000);
    wr(`LTT_OFF_RETRIES, 32'h0000_0001);
    hold <= 1'b1;
    send(4, 1'b0);
    idle(1);
    chk(rdy, 1'b0);
    chk(aod, 32'h0000_0001);
    chk(aov, 1'b1);
    chk(aol, 1'b0);
    hold <= 1'b0;
    idle(3);
    chk(rdy, 1'b1);
    send(195, 1'b0);
    idle(8);
    chk(go, 1'b0);
    send(1, 1'b1);
    idle(8);
    chk(go, 1'b1);
    wait_hi(1'b0);
    $display("test store and forward done");
    for (c = 3; c >= 1; c--)
    begin
      wr(`LTT_OFF_TUNING, {18'h0, c[1:0], 12'h000});
      nw = c == 3 ? 128 : c == 2 ? 256 : 435;
      send(nw - 1, 1'b0);
      idle(8);
      chk(go, 1'b0);
      send(1, 1'b0);
      idle(8);
      chk(go, 1'b1);
      send(1, 1'b1);
      wait_hi(1'b0);
    end
    send(5, 1'b1);
    idle(3);
    chk(go, 1'b1);
    wait_hi(1'b0);
    $display("test start levels done");
    wr(`LTT_OFF_TUNING, 32'h0000_3000);
    send(128, 1'b0);
    wait_hi(1'b1);
    chk(go, 1'b0);
    idle(2);
    chk(urun, 1'b0);
    send(20, 1'b0);
    idle(8);
    chk(go, 1'b0);
    send(1, 1'b1);
    idle(8);
    chk(go, 1'b1);
    wait_hi(1'b0);
    wr(`LTT_OFF_RETRIES, 32'h0000_0000);
    send(130, 1'b0);
    idle(8);
    chk(go, 1'b0);
    send(1, 1'b1);
    idle(8);
    chk(go, 1'b1);
    wait_hi(1'b0);
    $display("test underrun and retry done");
    final_report();
  end
endmodule : tb_ltt_top
